// *** spm_ctrl_pkg.sv ***
// constants for the self-programming flash control block
package flash_ctrl_pkg;
  localparam logic [11:0] PMCS_ADDR = 12'h0DC; // index 0x37, byte address 4*0x37
  localparam int PMCS_INDEX = 32'h37;
  localparam logic [7:0] PMCS_RESET = 8'h00;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_RFL = 3;
  localparam int BIT_CLRBUF = 4;
  localparam logic [4:0] CMD_CLRBUF = 5'h11;
  localparam logic [4:0] CMD_RFL = 5'h09;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_FILL = 5'h01;
  localparam logic [4:0] CTRL_MASK = 5'h1F;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  localparam int PAGE_WORDS = 16;
  localparam int PAGE_ADDR_W = 4;
  localparam int ZPTR_W = 16;
  localparam int PAGE_OP_NS = 4000;
  localparam int CLK_NS = 8;
  localparam int PAGE_OP_CYCLES = PAGE_OP_NS / CLK_NS;
  localparam logic [31:0] FUSE_DEFAULT = 32'h0000_00FF;
  localparam logic [31:0] LOCK_DEFAULT = 32'h0000_00FC;
endpackage : flash_ctrl_pkg

// *** self_program_flash_control.sv ***
// self-programming flash control: control register, windows, page buffer and sequencing
//
// Overview of operation
// - bits 7:5 of the control register read zero; writes to them are dropped.
// - clear_page_buffer command empties the temporary page buffer, losing loaded data.
// - read_fuse_lock plus enable lets a load in the second to fourth cycle return lock/fuse bits.
// - page_write plus enable makes a store within four cycles write buffer to page.
// - page_write clears when the write ends or the four-cycle window lapses.
// - core is held halted while a page write or erase is in progress.
// - page_erase plus enable makes a store within four cycles erase the page.
// - page_erase clears when the erase ends or the four-cycle window lapses.
// - store_prog_enable opens a store window of four cycles only.
// - enable alone makes a store put R0 into buffer word at pointer.
// - store_prog_enable clears after a store completes or the window lapses.
// - during page erase or write, store_prog_enable stays set until done.
// - only patterns 10001, 01001, 00101, 00011, 00001 in low bits take effect.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module self_program_flash_control
  import flash_ctrl_pkg::*;
#(
  parameter int PAGE_OP_CYCLES_P = PAGE_OP_CYCLES
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic store_program_instruction, // core issues a store-program, one pulse
  input wire logic load_program_instruction, // core issues a load-program, one pulse
  input wire logic [ZPTR_W-1:0] zpointer, // pointer operand
  input wire logic [15:0] store_data, // r0 operand
  output logic [7:0] load_data, // fuse or lock value for the load
  output logic load_valid, // load_data valid, one pulse
  output logic core_halt, // hold the core
  output logic flash_erase_pulse, // start page erase
  output logic flash_write_pulse, // start page write
  output logic [PAGE_ADDR_W-1:0] flash_page, // target page
  output logic [15:0] flash_wdata, // buffer word streamed for page write
  output logic [PAGE_ADDR_W-1:0] flash_word // buffer index of flash_wdata
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_BUSY = 2'b11
  } seq_state_type;

  localparam logic [15:0] OP_CNT_INIT = 16'(PAGE_OP_CYCLES_P);

  // sequencer state
  seq_state_type state_reg;
  seq_state_type state_next;
  logic [4:0] ctrl_reg;
  logic [4:0] ctrl_next;
  logic [2:0] win_reg;
  logic [2:0] win_next;
  logic [15:0] op_cnt_reg;
  logic [15:0] op_cnt_next;
  logic [PAGE_ADDR_W-1:0] page_reg;
  logic [PAGE_ADDR_W-1:0] page_next;

  // load answer and flash strobes
  logic [7:0] load_data_reg;
  logic [7:0] load_data_next;
  logic load_valid_reg;
  logic load_valid_next;
  logic erase_p_reg;
  logic erase_p_next;
  logic write_p_reg;
  logic write_p_next;

  // page buffer and write streaming
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] buf_valid_reg;
  logic [PAGE_WORDS-1:0] buf_valid_next;
  logic write_seen_reg;
  logic write_seen_next;
  logic [PAGE_ADDR_W-1:0] rd_idx_reg;
  logic [PAGE_ADDR_W-1:0] rd_idx_next;
  logic [15:0] wdata_reg;
  logic [15:0] wdata_next;
  logic [PAGE_ADDR_W-1:0] word_out_reg;
  logic [PAGE_ADDR_W-1:0] word_out_next;

  // decoded strobes
  logic hit;
  logic wr_access;
  logic cmd_ok;
  logic store_ok;
  logic load_ok;
  logic buf_store;
  logic end_of_op;
  logic [PAGE_ADDR_W-1:0] word_idx;

  // apb: zero wait state, always ready
  assign hit = (paddr == PMCS_ADDR);
  assign wr_access = psel && penable && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = (psel && hit) ? {27'h0, ctrl_reg} : 32'h0;

  always_comb begin
    case (pwdata[4:0])
      CMD_CLRBUF, CMD_RFL, CMD_WRITE, CMD_ERASE, CMD_FILL: begin
        cmd_ok = 1'b1;
      end
      default: begin
        cmd_ok = 1'b0;
      end
    endcase
  end

  // store is honoured only inside the open window
  assign store_ok = (state_reg == ST_ARMED) && store_program_instruction;
  assign load_ok = (state_reg == ST_ARMED) && load_program_instruction &&
                   ctrl_reg[BIT_RFL] && (win_reg <= LOAD_WINDOW);
  // pointer lsb is a byte select, ignored for word storage
  assign word_idx = zpointer[PAGE_ADDR_W:1];
  assign buf_store = store_ok && (ctrl_reg == CMD_FILL);
  assign end_of_op = (state_reg == ST_BUSY) && (op_cnt_reg <= 16'h0001);

  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    win_next = win_reg;
    op_cnt_next = op_cnt_reg;
    page_next = page_reg;
    load_data_next = load_data_reg;
    load_valid_next = 1'b0;
    erase_p_next = 1'b0;
    write_p_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (wr_access && cmd_ok) begin
          ctrl_next = pwdata[4:0] & CTRL_MASK;
          win_next = STORE_WINDOW;
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (store_ok && (ctrl_reg[BIT_WRITE] || ctrl_reg[BIT_ERASE])) begin
          page_next = zpointer[ZPTR_W-1 -: PAGE_ADDR_W];
          erase_p_next = ctrl_reg[BIT_ERASE];
          write_p_next = ctrl_reg[BIT_WRITE];
          op_cnt_next = OP_CNT_INIT;
          state_next = ST_BUSY;
        end else if (store_ok || load_ok) begin
          ctrl_next = 5'h00;
          state_next = ST_IDLE;
          if (load_ok) begin
            load_data_next = zpointer[0] ? LOCK_DEFAULT[7:0] : FUSE_DEFAULT[7:0];
            load_valid_next = 1'b1;
          end
        end else if (win_reg == 3'h1) begin
          ctrl_next = 5'h00;
          state_next = ST_IDLE;
        end else begin
          win_next = win_reg - 3'h1;
        end
      end
      ST_BUSY: begin
        // enable and command bits stand as a busy flag for polling
        if (op_cnt_reg <= 16'h0001) begin
          ctrl_next = 5'h00;
          state_next = ST_IDLE;
        end else begin
          op_cnt_next = op_cnt_reg - 16'h0001;
        end
      end
      default: begin
        state_next = ST_IDLE;
        ctrl_next = 5'h00;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      ctrl_reg <= PMCS_RESET[4:0];
      win_reg <= 3'h0;
      op_cnt_reg <= 16'h0000;
      page_reg <= '0;
      load_data_reg <= 8'h00;
      load_valid_reg <= 1'b0;
      erase_p_reg <= 1'b0;
      write_p_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      win_reg <= win_next;
      op_cnt_reg <= op_cnt_next;
      page_reg <= page_next;
      load_data_reg <= load_data_next;
      load_valid_reg <= load_valid_next;
      erase_p_reg <= erase_p_next;
      write_p_reg <= write_p_next;
    end
  end

  // clear command acts at once: valid bits drop, data is lost
  always_comb begin
    buf_valid_next = buf_valid_reg;
    if (state_reg == ST_IDLE && wr_access && (pwdata[4:0] == CMD_CLRBUF)) begin
      buf_valid_next = '0;
    end else if (end_of_op && write_seen_reg) begin
      // a finished page write leaves the buffer empty for the next fill
      buf_valid_next = '0;
    end else if (buf_store) begin
      buf_valid_next[word_idx] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_valid_reg <= '0;
    end else begin
      buf_valid_reg <= buf_valid_next;
    end
  end

  // marks a busy spell as a write, so an erase never streams the buffer
  always_comb begin
    write_seen_next = write_seen_reg;
    if (write_p_reg) begin
      write_seen_next = 1'b1;
    end else if (state_reg != ST_BUSY) begin
      write_seen_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_seen_reg <= 1'b0;
    end else begin
      write_seen_reg <= write_seen_next;
    end
  end

  // index walks one word a cycle and wraps on long operations
  always_comb begin
    rd_idx_next = rd_idx_reg;
    if (state_reg != ST_BUSY) begin
      rd_idx_next = '0;
    end else if (write_seen_reg) begin
      rd_idx_next = rd_idx_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_idx_reg <= '0;
    end else begin
      rd_idx_reg <= rd_idx_next;
    end
  end

  // word and index registered together so the output pair always matches
  always_comb begin
    word_out_next = rd_idx_reg;
    wdata_next = 16'hFFFF;
    if (buf_valid_reg[rd_idx_reg]) begin
      wdata_next = buf_mem[rd_idx_reg];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_reg <= 16'hFFFF;
      word_out_reg <= '0;
    end else begin
      wdata_reg <= wdata_next;
      word_out_reg <= word_out_next;
    end
  end

  // buffer storage has no reset; emptied words read back as erased
  genvar g;
  generate
    for (g = 0; g < PAGE_WORDS; g++) begin : g_buf
      always_ff @(posedge pclk) begin
        if (buf_store && word_idx == g) buf_mem[g] <= store_data;
      end
    end
  endgenerate

  assign core_halt = (state_reg == ST_BUSY);
  assign flash_erase_pulse = erase_p_reg;
  assign flash_write_pulse = write_p_reg;
  assign flash_page = page_reg;
  assign flash_wdata = wdata_reg;
  assign flash_word = word_out_reg;
  assign load_data = load_data_reg;
  assign load_valid = load_valid_reg;

endmodule : self_program_flash_control

// *** spm_ctrl_sva.sv ***
// assertions for the flash self-programming control block
`timescale 1ns/100ps
module flash_ctrl_sva
  import flash_ctrl_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic store_program_instruction, // store
  input wire logic load_program_instruction, // load
  input wire logic load_valid, // load done
  input wire logic core_halt, // halt
  input wire logic flash_erase_pulse, // erase
  input wire logic flash_write_pulse // write
);
  wire hit = psel && paddr == PMCS_ADDR;
  wire op = flash_erase_pulse || flash_write_pulse;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RSVD_ZERO: assert property (hit |-> prdata[31:5] == 27'h0)
    else $error("reserved bits read nonzero");
  AST_ERASE_CAUSE: assert property (flash_erase_pulse |-> $past(store_program_instruction))
    else $error("erase without store");
  AST_WRITE_CAUSE: assert property (flash_write_pulse |-> $past(store_program_instruction))
    else $error("write without store");
  AST_LOAD_CAUSE: assert property (load_valid |-> $past(load_program_instruction))
    else $error("load answer without load");
  AST_HALT_HOLD: assert property (op |=> core_halt [*2])
    else $error("core not halted");
  AST_BUSY_POLL: assert property (core_halt && hit |-> prdata[0])
    else $error("enable dropped while busy");
  AST_ONE_OP: assert property (op |=> !op)
    else $error("page operation started twice");
  AST_DONE_CLEAR: assert property ($fell(core_halt) && hit |-> prdata[2:1] == 2'h0)
    else $error("command bits left set");
endmodule : flash_ctrl_sva
bind self_program_flash_control flash_ctrl_sva flash_ctrl_sva_i (.*);

// *** core_model.sv ***
// core model: one store or load pulse a set number of cycles after a request
`timescale 1ns/100ps
module core_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic issue, // start one instruction
  input wire logic kind_load, // 1 load, 0 store
  input wire logic [2:0] gap, // edges after request
  output logic store_program_instruction, // one-cycle pulse
  output logic load_program_instruction // one-cycle pulse
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  always_comb begin
    cnt_next = (cnt_reg == 3'h0) ? 3'h0 : cnt_reg - 3'h1;
    if (issue) begin
      cnt_next = gap;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign store_program_instruction = cnt_reg == 3'h1 && !kind_load;
  assign load_program_instruction = cnt_reg == 3'h1 && kind_load;
endmodule : core_model

// *** self_program_flash_control_tb.sv ***
// self-checking bench for the flash self-programming control block
`timescale 1ns/100ps
module self_program_flash_control_tb;
  import flash_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, spi, lpi, issue, kl, err;
  logic load_valid, core_halt, fep, fwp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [15:0] zpointer, store_data, flash_wdata, d;
  logic [15:0] cap [16];
  logic [7:0] load_data, ld, v;
  logic [3:0] flash_page, flash_word, pg, w, p;
  logic [2:0] gap;
  logic [4:0] codes [5] = '{CMD_CLRBUF, CMD_RFL, CMD_WRITE, CMD_ERASE, CMD_FILL};
  int n_errors = 0;
  int samples_checked = 0;
  int wn = 0;
  int en = 0;
  int ln = 0;
  int w0, e0, l0;
  self_program_flash_control #(.PAGE_OP_CYCLES_P(20)) self_program_flash_control_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .store_program_instruction(spi), .load_program_instruction(lpi), .zpointer(zpointer),
    .store_data(store_data), .load_data(load_data), .load_valid(load_valid),
    .core_halt(core_halt), .flash_erase_pulse(fep), .flash_write_pulse(fwp),
    .flash_page(flash_page), .flash_wdata(flash_wdata), .flash_word(flash_word));
  core_model core_model_i (.pclk(pclk), .presetn(presetn), .issue(issue), .kind_load(kl),
    .gap(gap), .store_program_instruction(spi), .load_program_instruction(lpi));
  always @(posedge pclk) begin
    wn += fwp;
    en += fep;
    ln += load_valid;
    if (fwp) pg <= flash_page;
    if (load_valid) ld <= load_data;
    if (core_halt) cap[flash_word] <= flash_wdata;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic legal(input logic [7:0] c);
    return c[4:0] inside {CMD_CLRBUF, CMD_RFL, CMD_WRITE, CMD_ERASE, CMD_FILL};
  endfunction : legal
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] dv);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, 24'h0, dv};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {r, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask : apb
  // write a command, have the core act after g edges, then poll until idle
  task automatic op(input logic [4:0] c, input logic k, input logic [2:0] g);
    logic pg_op;
    pg_op = g < 3'h4 && (c == CMD_WRITE || c == CMD_ERASE);
    {w0, e0} = {wn, en};
    apb(1'b1, PMCS_ADDR, {3'h0, c});
    {kl, gap, issue} <= {k, g, 1'b1};
    @(posedge pclk);
    issue <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, PMCS_ADDR, 8'h0);
    chk(r, pg_op ? c : 5'h0);
    chk(core_halt, pg_op);
    for (int i = 0; i < 60 && core_halt !== 1'b0; i++) @(posedge pclk);
    apb(1'b0, PMCS_ADDR, 8'h0);
    chk(r, 32'h0);
    chk(wn - w0, pg_op && c == CMD_WRITE);
    chk(en - e0, pg_op && c == CMD_ERASE);
  endtask : op
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // whole run needs under 1500 cycles; 5000 leaves margin
  initial begin
    #40000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, issue, kl, paddr, pwdata, gap} = '0;
    {zpointer, store_data, seed} = {32'h0, 32'd73247};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, PMCS_ADDR, 8'h0);
    chk(r, {24'h0, PMCS_RESET});
    apb(1'b0, 12'h000, 8'h0);
    chk(err, 1'b1);
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      v = i < 5 ? {seed[7:5], codes[i % 5]} : seed[7:0];
      apb(1'b1, PMCS_ADDR, v);
      apb(1'b0, PMCS_ADDR, 8'h0);
      chk(r, legal(v) ? {27'h0, v[4:0]} : 32'h0);
      apb(1'b0, PMCS_ADDR, 8'h0);
      chk(r, 32'h0);
    end
    $display("test command patterns done");
    seed = xs(seed);
    {w, p, d} = {seed[3:0], seed[7:4], seed[31:16]};
    {zpointer, store_data} <= {11'h0, w, 1'b1, d};
    op(CMD_FILL, 1'b0, 3'h1);
    zpointer <= {p, 12'h0};
    op(CMD_WRITE, 1'b0, 3'h2);
    chk(cap[w], d);
    chk(pg, p);
    {zpointer, store_data} <= {11'h0, w, 1'b1, ~d};
    op(CMD_FILL, 1'b0, 3'h1);
    op(CMD_CLRBUF, 1'b0, 3'h4);
    zpointer <= {p, 12'h0};
    op(CMD_WRITE, 1'b0, 3'h3);
    chk(cap[w], 16'hFFFF);
    $display("test buffer and page write done");
    for (int g = 3; g < 5; g++) begin
      op(CMD_ERASE, 1'b0, 3'(g));
      op(CMD_WRITE, 1'b0, 3'(g));
    end
    $display("test window edges done");
    for (int z = 0; z < 2; z++) begin
      zpointer <= {15'h0, z[0]};
      l0 = ln;
      op(CMD_RFL, 1'b1, 3'(z + 2));
      chk(ln - l0, 1);
      chk(ld, z ? LOCK_DEFAULT[7:0] : FUSE_DEFAULT[7:0]);
    end
    $display("test fuse and lock read done");
    report_and_stop();
  end
endmodule : self_program_flash_control_tb
